// [rtl/cfr_pkg.sv]
package cfr_pkg;
    // ****************************************
    // link words and packet header layout
    // ****************************************
    localparam logic [31:0] SYNC_WORD = 32'hAA99_5566;
    localparam logic [2:0] HDR_TYPE1 = 3'h1;
    localparam logic [1:0] HDR_OP_WRITE = 2'h2;
    localparam int HDR_TYPE_MSB = 31;
    localparam int HDR_OP_MSB = 28;
    localparam int HDR_REG_MSB = 17;
    localparam int HDR_REG_LSB = 13;
    localparam int HDR_CNT_MSB = 10;
    // register addresses carried in the header
    localparam logic [4:0] RA_FADR = 5'h01;
    localparam logic [4:0] RA_FDIN = 5'h02;
    localparam logic [4:0] RA_CMD = 5'h04;
    localparam logic [4:0] RA_MCOPY = 5'h0A;
    localparam logic [4:0] RA_FLEN = 5'h0B;
    localparam logic [4:0] RA_KEY = 5'h0C;
    localparam logic [4:0] RA_CHAIN = 5'h0D;
    localparam logic [4:0] RA_IDENT = 5'h0E;
    // command codes
    localparam logic [31:0] CMD_WRCONF = 32'h0000_0001;
    localparam logic [31:0] CMD_MCOPY = 32'h0000_0002;
    localparam logic [31:0] HDR_MCOPY_PAD2 = 32'h3001_4002;
    // device identity; the value is arbitrary
    localparam logic [31:0] DEV_CODE = 32'h0A5C_3001;
    // frame buffer sizing
    localparam int FLEN_W = 8;
    localparam int FBUF_DEPTH = 256;
    localparam logic [1:0] MF_PADS = 2'h2;
    // ****************************************
    // controller APB map
    // ****************************************
    localparam logic [7:0] OFS_TX = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_PAD_PAIR = 8'h10;
    localparam int IRQ_W = 3;

    // header fields, shared by both ends
    function automatic logic hdr_is_wr1(input logic [31:0] w);
        hdr_is_wr1 = (w[31:29] == HDR_TYPE1) && (w[28:27] == HDR_OP_WRITE);
    endfunction : hdr_is_wr1

    function automatic logic [4:0] hdr_reg(input logic [31:0] w);
        hdr_reg = w[HDR_REG_MSB:HDR_REG_LSB];
    endfunction : hdr_reg

    function automatic logic [10:0] hdr_cnt(input logic [31:0] w);
        hdr_cnt = w[HDR_CNT_MSB:0];
    endfunction : hdr_cnt
endpackage : cfr_pkg

// [rtl/cfr_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
// word stream from controller to loader, plus loader status
interface cfr_link_if;
    logic word_valid;
    logic word_ready;
    logic [31:0] word;
    logic ident_mismatch_flag;
    logic synced;
    modport dev (input word_valid, input word, output word_ready,
                 output ident_mismatch_flag, output synced);
    modport host (output word_valid, output word, input word_ready,
                  input ident_mismatch_flag, input synced);
endinterface : cfr_link_if
`default_nettype wire

// [rtl/cfr_loader.sv]
`timescale 1ns/100ps
`default_nettype none
// Function
// - multi-frame mode copies buffer to each address
// - host: write cmd, frame, address, copy command
// - host: two pad words after each address
// - commands are one-word writes to command register
// - frame address is one full data word
// - frame load then one excluded check word
// - host programs frame length before frame data
// - frame length holds words per frame minus one
// - key count writable, never readable
// - chaining keys stored, never returned
// - own identity register with device code
// - identity write compared; mismatch flags, halts
// - frame writes only after matching identity write
// - frame address advances after each loaded frame
// - word after frame load is check word
// - ignore everything until the sync word
module cfr_loader (
    input wire logic pclk,
    input wire logic presetn,
    cfr_link_if.dev link,
    output logic frame_wr_valid,
    output logic [31:0] frame_wr_addr,
    output logic [cfr_pkg::FLEN_W-1:0] frame_wr_index,
    output logic [31:0] frame_wr_data,
    output logic ident_ok
);
    // ****************************************
    // parser state
    // ****************************************
    typedef enum logic [4:0] {
        ST_HUNT = 5'b00001,
        ST_HDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_CRC = 5'b01000,
        ST_COPY = 5'b10000
    } cfr_state_t;

    cfr_state_t state_reg;
    cfr_state_t ret_reg;
    logic [4:0] sel_reg;
    logic [10:0] cnt_reg;
    logic wcmd_reg;
    logic mf_reg;
    logic [1:0] pad_reg;
    logic [31:0] fadr_reg;
    logic [cfr_pkg::FLEN_W-1:0] flen_reg;
    logic [cfr_pkg::FLEN_W-1:0] widx_reg;
    logic [cfr_pkg::FLEN_W-1:0] cidx_reg;
    logic adv_reg;
    logic id_ok_reg;
    logic mismatch_reg;
    logic [31:0] key_count_reg;
    logic [63:0] chain_key_reg;
    logic [31:0] fbuf [cfr_pkg::FBUF_DEPTH];

    logic take;
    logic [31:0] w;
    logic last_word;
    logic frame_ok;
    logic fdin_wr;
    logic frame_done;
    logic mf_trig;

    // stall the link only while the buffer is being copied out
    assign link.word_ready = (state_reg != ST_COPY);
    assign take = link.word_valid && link.word_ready;
    assign w = link.word;
    assign last_word = (cnt_reg == 11'h001);
    // frame data is refused without a matching identity write
    assign frame_ok = wcmd_reg && id_ok_reg && !mismatch_reg;
    assign fdin_wr = take && (state_reg == ST_DATA) && (sel_reg == cfr_pkg::RA_FDIN) && frame_ok;
    assign frame_done = fdin_wr && (widx_reg == flen_reg);
    // copy fires on the second pad write, whatever the pad holds
    assign mf_trig = take && (state_reg == ST_DATA) && (sel_reg == cfr_pkg::RA_MCOPY)
                     && mf_reg && frame_ok && (pad_reg == cfr_pkg::MF_PADS - 2'h1);
    assign link.ident_mismatch_flag = mismatch_reg;
    assign link.synced = (state_reg != ST_HUNT);
    assign ident_ok = id_ok_reg;

    // ****************************************
    // packet walk
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_HUNT;
            ret_reg <= ST_HDR;
            sel_reg <= 5'h00;
            cnt_reg <= 11'h000;
        end else begin
            case (state_reg)
                ST_HUNT: begin
                    if (take && (w == cfr_pkg::SYNC_WORD)) begin
                        state_reg <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    // only type-1 writes with a payload open a data phase
                    if (take && cfr_pkg::hdr_is_wr1(w) && (cfr_pkg::hdr_cnt(w) != 11'h000)) begin
                        sel_reg <= cfr_pkg::hdr_reg(w);
                        cnt_reg <= cfr_pkg::hdr_cnt(w);
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (take) begin
                        cnt_reg <= cnt_reg - 11'h001;
                        if ((sel_reg == cfr_pkg::RA_IDENT) && (w != cfr_pkg::DEV_CODE)) begin
                            state_reg <= ST_HUNT;
                        end else if (frame_done || mf_trig) begin
                            state_reg <= ST_COPY;
                            if (last_word && (sel_reg == cfr_pkg::RA_FDIN)) begin
                                ret_reg <= ST_CRC;
                            end else if (last_word) begin
                                ret_reg <= ST_HDR;
                            end else begin
                                ret_reg <= ST_DATA;
                            end
                        end else if (last_word && (sel_reg == cfr_pkg::RA_FDIN)) begin
                            state_reg <= ST_CRC;
                        end else if (last_word) begin
                            state_reg <= ST_HDR;
                        end
                    end
                end
                ST_CRC: begin
                    // check word is consumed, never parsed as a header
                    if (take) begin
                        state_reg <= ST_HDR;
                    end
                end
                ST_COPY: begin
                    if (cidx_reg == flen_reg) begin
                        state_reg <= ret_reg;
                    end
                end
                default: begin
                    state_reg <= ST_HUNT;
                end
            endcase
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcmd_reg <= 1'b0;
            mf_reg <= 1'b0;
            flen_reg <= '0;
            key_count_reg <= 32'h0000_0000;
            chain_key_reg <= 64'h0000_0000_0000_0000;
        end else if (take && (state_reg == ST_DATA)) begin
            if (sel_reg == cfr_pkg::RA_CMD) begin
                if (w == cfr_pkg::CMD_WRCONF) begin
                    wcmd_reg <= 1'b1;
                    mf_reg <= 1'b0;
                end else if (w == cfr_pkg::CMD_MCOPY) begin
                    mf_reg <= 1'b1;
                end
            end else if (sel_reg == cfr_pkg::RA_FLEN) begin
                flen_reg <= w[cfr_pkg::FLEN_W-1:0];
            end else if (sel_reg == cfr_pkg::RA_KEY) begin
                key_count_reg <= w; // no read path exists
            end else if (sel_reg == cfr_pkg::RA_CHAIN) begin
                chain_key_reg <= {chain_key_reg[31:0], w}; // stays internal
            end
        end
    end

    // identity check; a resync clears a mismatch, a match survives it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_ok_reg <= 1'b0;
            mismatch_reg <= 1'b0;
        end else if (take && (state_reg == ST_DATA) && (sel_reg == cfr_pkg::RA_IDENT)) begin
            id_ok_reg <= (w == cfr_pkg::DEV_CODE);
            mismatch_reg <= (w != cfr_pkg::DEV_CODE);
        end else if (take && (state_reg == ST_HUNT) && (w == cfr_pkg::SYNC_WORD)) begin
            mismatch_reg <= 1'b0;
        end
    end

    // ****************************************
    // frame address and buffer fill
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fadr_reg <= 32'h0000_0000;
            widx_reg <= '0;
            pad_reg <= 2'h0;
            adv_reg <= 1'b0;
        end else if ((state_reg == ST_COPY) && (cidx_reg == flen_reg)) begin
            // advance only after a loaded frame, never after a replica
            if (adv_reg) begin
                fadr_reg <= fadr_reg + 32'h0000_0001;
            end
        end else if (take && (state_reg == ST_DATA)) begin
            if (sel_reg == cfr_pkg::RA_FADR) begin
                fadr_reg <= w;
                pad_reg <= 2'h0;
            end else if (fdin_wr) begin
                widx_reg <= frame_done ? '0 : widx_reg + 1'b1;
                adv_reg <= 1'b1;
            end else if ((sel_reg == cfr_pkg::RA_MCOPY) && mf_reg && frame_ok) begin
                pad_reg <= mf_trig ? 2'h0 : pad_reg + 2'h1;
                adv_reg <= 1'b0;
            end
        end
    end

    // buffer memory has no reset, it is only written behind a valid fill
    always_ff @(posedge pclk) begin
        if (fdin_wr) begin
            fbuf[widx_reg] <= w;
        end
    end

    // ****************************************
    // copy engine
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cidx_reg <= '0;
            frame_wr_valid <= 1'b0;
            frame_wr_addr <= 32'h0000_0000;
            frame_wr_index <= '0;
            frame_wr_data <= 32'h0000_0000;
        end else if (state_reg == ST_COPY) begin
            frame_wr_valid <= 1'b1;
            frame_wr_addr <= fadr_reg;
            frame_wr_index <= cidx_reg;
            frame_wr_data <= fbuf[cidx_reg];
            cidx_reg <= (cidx_reg == flen_reg) ? '0 : cidx_reg + 1'b1;
        end else begin
            frame_wr_valid <= 1'b0;
        end
    end
endmodule : cfr_loader
`default_nettype wire

// [rtl/cfr_host.sv]
`timescale 1ns/100ps
`default_nettype none
// APB-driven word pusher feeding the loader link
module cfr_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    cfr_link_if.host link
);
    logic tx_valid_reg;
    logic [31:0] tx_word_reg;
    logic [1:0] pad_left_reg;
    logic [10:0] cnt_reg;
    logic flen_seen_reg;
    logic id_seen_reg;
    logic [cfr_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [cfr_pkg::IRQ_W-1:0] irq_mask_reg;
    logic mism_d_reg;
    logic acc;
    logic wr_tx;
    logic wr_pad;
    logic early_fdin;
    logic sent;
    logic [cfr_pkg::IRQ_W-1:0] ev;

    // ****************************************
    // APB slave
    // ****************************************
    assign acc = psel && penable;
    // a sending request waits until the previous word has gone
    assign pready = !((paddr == cfr_pkg::OFS_TX || paddr == cfr_pkg::OFS_PAD_PAIR)
                      && pwrite && (tx_valid_reg || pad_left_reg != 2'h0));
    // frame data header before length and identity is refused
    assign early_fdin = (cnt_reg == 11'h000) && cfr_pkg::hdr_is_wr1(pwdata)
                        && (cfr_pkg::hdr_reg(pwdata) == cfr_pkg::RA_FDIN)
                        && !(flen_seen_reg && id_seen_reg);
    assign wr_tx = acc && pready && pwrite && (paddr == cfr_pkg::OFS_TX) && !early_fdin;
    assign wr_pad = acc && pready && pwrite && (paddr == cfr_pkg::OFS_PAD_PAIR);
    assign sent = link.word_valid && link.word_ready;
    assign ev = {link.ident_mismatch_flag && !mism_d_reg, wr_pad, sent};
    assign irq = |(irq_stat_reg & irq_mask_reg);
    assign link.word_valid = tx_valid_reg;
    assign link.word = tx_word_reg;

    // answer decode; unmapped accesses and refused writes report slverr
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == cfr_pkg::OFS_STATUS) begin
            prdata = {28'h000_0000, flen_seen_reg && id_seen_reg, link.synced,
                      link.ident_mismatch_flag, tx_valid_reg};
        end else if (paddr == cfr_pkg::OFS_IRQ_STAT) begin
            prdata = {29'h0000_0000, irq_stat_reg};
        end else if (paddr == cfr_pkg::OFS_IRQ_MASK) begin
            prdata = {29'h0000_0000, irq_mask_reg};
        end else if (paddr == cfr_pkg::OFS_TX) begin
            pslverr = pwrite && early_fdin;
        end else if (paddr != cfr_pkg::OFS_PAD_PAIR) begin
            pslverr = 1'b1;
        end
    end

    // ****************************************
    // transmit word and pad-pair sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_reg <= 1'b0;
            tx_word_reg <= 32'h0000_0000;
            pad_left_reg <= 2'h0;
        end else if (wr_tx) begin
            tx_valid_reg <= 1'b1;
            tx_word_reg <= pwdata;
        end else if (wr_pad) begin
            tx_valid_reg <= 1'b1;
            tx_word_reg <= cfr_pkg::HDR_MCOPY_PAD2;
            pad_left_reg <= cfr_pkg::MF_PADS;
        end else if (sent && pad_left_reg != 2'h0) begin
            tx_word_reg <= 32'h0000_0000; // content is don't-care
            pad_left_reg <= pad_left_reg - 2'h1;
        end else if (sent) begin
            tx_valid_reg <= 1'b0;
        end
    end

    // track headers versus payload so the order guard sees headers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 11'h000;
            flen_seen_reg <= 1'b0;
            id_seen_reg <= 1'b0;
        end else if (sent && cnt_reg != 11'h000) begin
            cnt_reg <= cnt_reg - 11'h001;
        end else if (sent && cfr_pkg::hdr_is_wr1(link.word)) begin
            // a frame load also owns the uncounted check word behind it
            cnt_reg <= cfr_pkg::hdr_cnt(link.word)
                       + {10'h000, cfr_pkg::hdr_reg(link.word) == cfr_pkg::RA_FDIN};
            if (cfr_pkg::hdr_reg(link.word) == cfr_pkg::RA_FLEN) begin
                flen_seen_reg <= 1'b1;
            end
            if (cfr_pkg::hdr_reg(link.word) == cfr_pkg::RA_IDENT) begin
                id_seen_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // interrupts; a new event beats a same-cycle clear
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            mism_d_reg <= 1'b0;
        end else begin
            mism_d_reg <= link.ident_mismatch_flag;
            if (acc && pwrite && paddr == cfr_pkg::OFS_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[cfr_pkg::IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev;
            end
            if (acc && pwrite && paddr == cfr_pkg::OFS_IRQ_MASK) begin
                irq_mask_reg <= pwdata[cfr_pkg::IRQ_W-1:0];
            end
        end
    end
endmodule : cfr_host
`default_nettype wire

// [tb/cfr_link_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// link and copy port properties
// ****************************************
module cfr_link_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic [31:0] word,
    input wire logic ident_mismatch_flag,
    input wire logic synced,
    input wire logic frame_wr_valid,
    input wire logic [31:0] frame_wr_addr,
    input wire logic [cfr_pkg::FLEN_W-1:0] frame_wr_index
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic sync_take;
    // sync word taken on the link in this cycle
    assign sync_take = word_valid && word_ready && (word == cfr_pkg::SYNC_WORD);
    // an offered word must not change before it is taken
    property p_word_hold;
        word_valid && !word_ready |=> word_valid && $stable(word);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("link word changed while waiting");
    property p_copy_start;
        $rose(frame_wr_valid) |-> frame_wr_index == '0;
    endproperty
    a_copy_start: assert property (p_copy_start) else $error("copy not starting at word 0");
    property p_index_step;
        frame_wr_valid && $past(frame_wr_valid) |-> frame_wr_index == $past(frame_wr_index) + 1'b1;
    endproperty
    a_index_step: assert property (p_index_step) else $error("copy index skipped");
    property p_addr_hold;
        frame_wr_valid && $past(frame_wr_valid) |-> frame_wr_addr == $past(frame_wr_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("copy address moved mid frame");
    // each copy beat was launched while the link stood stalled
    property p_copy_stall;
        frame_wr_valid |-> !$past(word_ready);
    endproperty
    a_copy_stall: assert property (p_copy_stall) else $error("link not stalled during copy");
    property p_sync_cause;
        $rose(synced) |-> $past(sync_take);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("synced without sync word");
    property p_flag_hold;
        ident_mismatch_flag && !sync_take |=> ident_mismatch_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("mismatch flag cleared early");
    // a mismatch halts: no sync, no copies
    property p_flag_halt;
        ident_mismatch_flag && !$past(sync_take) |-> !synced && !frame_wr_valid;
    endproperty
    a_flag_halt: assert property (p_flag_halt) else $error("loader active after mismatch");
    property p_flag_rise;
        $rose(ident_mismatch_flag) |-> $past(word_valid && word_ready);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("mismatch flag without a word");
    c_copy: cover property ($rose(frame_wr_valid));
    c_mismatch: cover property ($rose(ident_mismatch_flag));
    c_resync: cover property ($rose(synced));
endmodule : cfr_link_properties
`default_nettype wire

// [tb/config_frame_replicate_and_id_check_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module config_frame_replicate_and_id_check_tb_top;
    // ****************************************
    // harness
    // ****************************************
    localparam int FWORDS = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, frame_wr_addr, frame_wr_data;
    logic frame_wr_valid, ident_ok;
    logic [cfr_pkg::FLEN_W-1:0] frame_wr_index;
    logic [31:0] fbuf [FWORDS];
    logic [71:0] exp_q [$];
    int fails, cmp_count;
    cfr_link_if cfr_link_if_inst ();
    cfr_host cfr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(cfr_link_if_inst));
    cfr_loader cfr_loader_inst (.pclk(pclk), .presetn(presetn), .link(cfr_link_if_inst),
        .frame_wr_valid(frame_wr_valid), .frame_wr_addr(frame_wr_addr),
        .frame_wr_index(frame_wr_index), .frame_wr_data(frame_wr_data), .ident_ok(ident_ok));
    cfr_link_properties cfr_link_properties_inst (.pclk(pclk), .presetn(presetn),
        .word_valid(cfr_link_if_inst.word_valid), .word_ready(cfr_link_if_inst.word_ready),
        .word(cfr_link_if_inst.word), .ident_mismatch_flag(cfr_link_if_inst.ident_mismatch_flag),
        .synced(cfr_link_if_inst.synced), .frame_wr_valid(frame_wr_valid),
        .frame_wr_addr(frame_wr_addr), .frame_wr_index(frame_wr_index));
    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [31:0] hdr(input logic [4:0] r, input logic [10:0] n);
        hdr = {3'h1, 2'h2, 9'h0, r, 2'h0, n};
    endfunction : hdr
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // one apb transfer; waits on pready, the watchdog bounds a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic tx(input logic [31:0] w);
        apb(1'b1, cfr_pkg::OFS_TX, w);
    endtask : tx
    // poll status until the host has no word pending, then let a copy finish
    task automatic drain;
        do begin
            apb(1'b0, cfr_pkg::OFS_STATUS, 32'h0000_0000);
        end while (rd[0] !== 1'b0);
        repeat (FWORDS + 2) @(posedge pclk);
    endtask : drain
    task automatic status(input logic [3:0] e);
        apb(1'b0, cfr_pkg::OFS_STATUS, 32'h0000_0000);
        check("status", {28'h0, rd[3:0]}, {28'h0, e});
    endtask : status
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask : chk_irq
    // note one buffered frame going to addr
    task automatic frame(input logic [31:0] addr);
        for (int i = 0; i < FWORDS; i++) exp_q.push_back({addr, 8'(i), fbuf[i]});
    endtask : frame
    // ****************************************
    // copy port monitor
    // ****************************************
    always @(posedge pclk) begin
        if (frame_wr_valid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected copy", 32'h1, 32'h0);
            else begin
                check("copy addr", frame_wr_addr, exp_q[0][71:40]);
                check("copy index", 32'(frame_wr_index), 32'(exp_q[0][39:32]));
                check("copy data", frame_wr_data, exp_q[0][31:0]);
                void'(exp_q.pop_front());
            end
        end
    end
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(94));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, cfr_pkg::OFS_TX, hdr(cfr_pkg::RA_FDIN, 11'd4));
        check("early frame header", {31'h0, err}, 32'h1);
        for (int i = 0; i < 4; i++) tx($urandom() & 32'h0FFF_FFFF);
        drain();
        status(4'b0000);
        tx(cfr_pkg::SYNC_WORD);
        tx(hdr(cfr_pkg::RA_FLEN, 11'd1));
        tx(32'(FWORDS - 1));
        tx(hdr(cfr_pkg::RA_KEY, 11'd1));
        tx(32'h0000_0002);
        tx(hdr(cfr_pkg::RA_CHAIN, 11'd2));
        tx($urandom());
        tx($urandom());
        tx(hdr(cfr_pkg::RA_IDENT, 11'd1));
        tx(cfr_pkg::DEV_CODE);
        drain();
        check("ident ok", {31'h0, ident_ok}, 32'h1);
        status(4'b1100);
        tx(hdr(cfr_pkg::RA_FADR, 11'd1));
        tx(32'h0000_00A0);
        tx(hdr(cfr_pkg::RA_CMD, 11'd1));
        tx(cfr_pkg::CMD_WRCONF);
        tx(hdr(cfr_pkg::RA_FDIN, 11'(2 * FWORDS)));
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < FWORDS; i++) fbuf[i] = $urandom();
            frame(32'h0000_00A0 + 32'(f));
            for (int i = 0; i < FWORDS; i++) tx(fbuf[i]);
        end
        tx(hdr(cfr_pkg::RA_FDIN, 11'd4));
        tx(hdr(cfr_pkg::RA_FADR, 11'd1));
        tx(32'h0000_0200);
        tx(hdr(cfr_pkg::RA_CMD, 11'd1));
        tx(cfr_pkg::CMD_MCOPY);
        frame(32'h0000_0200);
        apb(1'b1, cfr_pkg::OFS_PAD_PAIR, $urandom());
        tx(hdr(cfr_pkg::RA_FADR, 11'd1));
        tx(32'h0000_0400);
        frame(32'h0000_0400);
        tx(cfr_pkg::HDR_MCOPY_PAD2);
        tx($urandom());
        tx($urandom());
        drain();
        check("copies left", 32'(exp_q.size()), 32'h0);
        apb(1'b0, cfr_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        check("irq status", {29'h0, rd[2:0]}, 32'h3);
        chk_irq(1'b0);
        apb(1'b1, cfr_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        chk_irq(1'b1);
        apb(1'b1, cfr_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        chk_irq(1'b0);
        apb(1'b1, cfr_pkg::OFS_IRQ_MASK, 32'h0000_0004);
        // wrong identity, then frame traffic that must go nowhere
        tx(cfr_pkg::SYNC_WORD);
        tx(hdr(cfr_pkg::RA_IDENT, 11'd1));
        tx(cfr_pkg::DEV_CODE ^ 32'h0000_0100);
        drain();
        status(4'b1010);
        chk_irq(1'b1);
        tx(hdr(cfr_pkg::RA_CMD, 11'd1));
        tx(cfr_pkg::CMD_WRCONF);
        tx(hdr(cfr_pkg::RA_FDIN, 11'(FWORDS)));
        for (int i = 0; i < FWORDS; i++) tx($urandom());
        drain();
        check("ident after mismatch", {31'h0, ident_ok}, 32'h0);
        tx(cfr_pkg::SYNC_WORD);
        drain();
        status(4'b1100);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped err", {31'h0, err}, 32'h1);
        stop_test();
    end
endmodule : config_frame_replicate_and_id_check_tb_top
`default_nettype wire
